// ---- core_regs_pkg.sv ----
// Constants for the core flag, pointer and memory map register block
package core_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets in the special-function space
  // ---------------------------------------------------------------
  localparam logic [7:0] STACK_TOP_ADDR = 8'h81;
  localparam logic [7:0] PTR0_LOW_ADDR = 8'h82;
  localparam logic [7:0] PTR0_HIGH_ADDR = 8'h83;
  localparam logic [7:0] PTR1_LOW_ADDR = 8'h84;
  localparam logic [7:0] PTR1_HIGH_ADDR = 8'h85;
  localparam logic [7:0] MEM_TIMING_ADDR = 8'h8e;
  localparam logic [7:0] POINTER_CHOICE_ADDR = 8'h92;
  localparam logic [7:0] CPU_FLAGS_ADDR = 8'hd0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STACK_TOP_RESET = 8'h07;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [2:0] WAIT_RESET = 3'h0;
  localparam logic [2:0] STRETCH_RESET = 3'h1;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CARRY_BIT = 7;
  localparam int NIBBLE_BIT = 6;
  localparam int USER_A_BIT = 5;
  localparam int BANK_HI_BIT = 4;
  localparam int BANK_LO_BIT = 3;
  localparam int WRAP_BIT = 2;
  localparam int USER_B_BIT = 1;
  localparam int PARITY_BIT = 0;
  localparam int WAIT_LSB = 4;
  localparam int STRETCH_LSB = 0;
  localparam int CHOICE_BIT = 0;

  // ---------------------------------------------------------------
  // Memory map
  // ---------------------------------------------------------------
  localparam int SCRATCH_DEPTH = 256;
  localparam logic [7:0] DIRECT_LIMIT = 8'h80;
  localparam int XRAM_DEPTH = 2048;
  localparam logic [15:0] XRAM_BASE = 16'h8000;
  localparam logic [15:0] XRAM_LAST = 16'h87ff;
  localparam logic [7:0] PAGE_HIGH = 8'h80;

  // External data address sources
  typedef enum logic [1:0] {
    XSRC_ADDR,
    XSRC_POINTER,
    XSRC_PAGED
  } xsrc_t;

endpackage : core_regs_pkg

// ---- byte_ram.sv ----
// Single-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Access port
  input wire logic [AW-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Contents are not reset, as in a real SRAM macro
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
    rdata <= rd ? mem[addr] : 8'h00;
  end

endmodule : byte_ram
`default_nettype wire

// ---- core_flags_pointers.sv ----
// Core flags, stack, data pointers, memory timing and RAM map
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Flags reset zero; bit 7 is carry
// - Bit 6 set on nibble carry
// - Bits 4:3 pick register bank
// - Bit 2 set on signed overflow
// - Bit 0 is live accumulator parity
// - Bits 5 and 1 plain user flags
// - Stack resets 0x07, pre-increment, post-decrement
// - Pointers usable whole or by byte
// - Choice bit 0 selects active pointer
// - Active pointer addresses indirect external accesses
// - 256-byte scratch, upper half indirect only
// - 2048-byte RAM at 0x8000 to 0x87FF
// - Timing resets 0x01; wait states zero
// - Stretch field defaults to one cycle
// - Paged accesses land at page 0x8000
module core_flags_pointers (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Arithmetic results
  input wire logic [7:0] acc,
  input wire logic alu_upd,
  input wire logic alu_carry,
  input wire logic alu_nibble_carry,
  input wire logic alu_wrap,
  input wire logic bool_wr,
  input wire logic bool_val,
  // Stack operations
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [7:0] push_data,
  // Pointer increment
  input wire logic ptr_inc,
  // Scratch RAM port
  input wire logic [7:0] ram_addr,
  input wire logic ram_direct,
  input wire logic ram_bank_reg,
  input wire logic ram_wr,
  input wire logic ram_rd,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  // External RAM port
  input wire logic [1:0] x_src,
  input wire logic [15:0] x_addr,
  input wire logic x_wr,
  input wire logic x_rd,
  input wire logic [7:0] x_wdata,
  output logic [7:0] x_rdata,
  output logic x_hit,
  // Core status
  output logic [7:0] cpu_flags,
  output logic [7:0] stack_top,
  output logic [15:0] indirect_addr_ptr,
  output logic [7:0] bank_base,
  output logic [2:0] wait_states,
  output logic [2:0] stretch_cycles
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic carry_flag;
    logic nibble_carry_flag;
    logic user_flag_a;
    logic [1:0] bank_select;
    logic arith_wrap_flag;
    logic user_flag_b;
    logic [7:0] stack_top;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic pointer_choice;
    logic [2:0] wait_states;
    logic [2:0] stretch_cycles;
    logic [7:0] rdata;
    logic x_rd_hit;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Odd parity: one when an odd number of bits are set
  function automatic logic odd_parity(input logic [7:0] v);
    odd_parity = ^v;
  endfunction : odd_parity

  // Working register address within the chosen bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] idx);
    bank_addr = {3'h0, bank, idx};
  endfunction : bank_addr

  function automatic logic [7:0] flags_word(input state_t s, input logic [7:0] a);
    flags_word = {s.carry_flag, s.nibble_carry_flag, s.user_flag_a, s.bank_select,
                  s.arith_wrap_flag, s.user_flag_b, odd_parity(a)};
  endfunction : flags_word

  logic [15:0] active_ptr;
  logic [15:0] x_eff;
  logic x_in_range;
  logic [7:0] scratch_addr;
  logic scratch_wr;
  logic scratch_rd;
  logic [7:0] scratch_wdata;
  logic [7:0] scratch_rdata;
  logic [7:0] xram_rdata;
  logic direct_refused;

  assign active_ptr = cur.pointer_choice ? cur.ptr1 : cur.ptr0;

  // ---------------------------------------------------------------
  // External address decode
  // ---------------------------------------------------------------
  always_comb begin
    unique case (core_regs_pkg::xsrc_t'(x_src))
      core_regs_pkg::XSRC_POINTER: x_eff = active_ptr;
      core_regs_pkg::XSRC_PAGED: x_eff = {core_regs_pkg::PAGE_HIGH, x_addr[7:0]};
      default: x_eff = x_addr;
    endcase
  end

  assign x_in_range = (x_eff >= core_regs_pkg::XRAM_BASE) && (x_eff <= core_regs_pkg::XRAM_LAST);
  assign x_hit = x_in_range;

  // ---------------------------------------------------------------
  // Scratch RAM arbitration
  // ---------------------------------------------------------------
  // Direct addresses at and above the limit belong to the register space
  // upper half indirect only
  assign direct_refused = ram_direct && !ram_bank_reg && (ram_addr >= core_regs_pkg::DIRECT_LIMIT);

  // Stack traffic wins the single port; the core must not overlap the two
  always_comb begin
    scratch_addr = ram_addr;
    scratch_wr = ram_wr && !direct_refused;
    scratch_rd = ram_rd && !direct_refused;
    scratch_wdata = ram_wdata;
    if (push_req) begin
      scratch_addr = cur.stack_top + 8'h01;
      scratch_wr = 1'b1;
      scratch_rd = 1'b0;
      scratch_wdata = push_data;
    end else if (pop_req) begin
      scratch_addr = cur.stack_top;
      scratch_wr = 1'b0;
      scratch_rd = 1'b1;
    end else if (ram_bank_reg) begin
      scratch_addr = bank_addr(cur.bank_select, ram_addr[2:0]);
    end
  end

  byte_ram #(
    .DEPTH(core_regs_pkg::SCRATCH_DEPTH),
    .AW(8)
  ) u_scratch (
    .clk(clk),
    .addr(scratch_addr),
    .wr(scratch_wr),
    .rd(scratch_rd),
    .wdata(scratch_wdata),
    .rdata(scratch_rdata)
  );

  byte_ram #(
    .DEPTH(core_regs_pkg::XRAM_DEPTH),
    .AW(11)
  ) u_xram (
    .clk(clk),
    .addr(x_eff[10:0]),
    .wr(x_wr && x_in_range),
    .rd(x_rd && x_in_range),
    .wdata(x_wdata),
    .rdata(xram_rdata)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.x_rd_hit = x_rd && x_in_range;
    next_cur.rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        core_regs_pkg::STACK_TOP_ADDR: next_cur.rdata = cur.stack_top;
        core_regs_pkg::PTR0_LOW_ADDR: next_cur.rdata = cur.ptr0[7:0];
        core_regs_pkg::PTR0_HIGH_ADDR: next_cur.rdata = cur.ptr0[15:8];
        core_regs_pkg::PTR1_LOW_ADDR: next_cur.rdata = cur.ptr1[7:0];
        core_regs_pkg::PTR1_HIGH_ADDR: next_cur.rdata = cur.ptr1[15:8];
        core_regs_pkg::MEM_TIMING_ADDR: next_cur.rdata = {1'b0, cur.wait_states, 1'b0, cur.stretch_cycles};
        core_regs_pkg::POINTER_CHOICE_ADDR: next_cur.rdata = {7'h00, cur.pointer_choice};
        core_regs_pkg::CPU_FLAGS_ADDR: next_cur.rdata = flags_word(cur, acc);
        default: next_cur.rdata = 8'h00;
      endcase
    end
    if (ptr_inc) begin
      if (cur.pointer_choice) begin
        next_cur.ptr1 = cur.ptr1 + 16'h0001;
      end else begin
        next_cur.ptr0 = cur.ptr0 + 16'h0001;
      end
    end
    if (push_req) begin
      next_cur.stack_top = cur.stack_top + 8'h01;
    end else if (pop_req) begin
      next_cur.stack_top = cur.stack_top - 8'h01;
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        core_regs_pkg::STACK_TOP_ADDR: next_cur.stack_top = sfr_wdata;
        core_regs_pkg::PTR0_LOW_ADDR: next_cur.ptr0[7:0] = sfr_wdata;
        core_regs_pkg::PTR0_HIGH_ADDR: next_cur.ptr0[15:8] = sfr_wdata;
        core_regs_pkg::PTR1_LOW_ADDR: next_cur.ptr1[7:0] = sfr_wdata;
        core_regs_pkg::PTR1_HIGH_ADDR: next_cur.ptr1[15:8] = sfr_wdata;
        core_regs_pkg::MEM_TIMING_ADDR: begin
          next_cur.wait_states = sfr_wdata[core_regs_pkg::WAIT_LSB +: 3];
          next_cur.stretch_cycles = sfr_wdata[core_regs_pkg::STRETCH_LSB +: 3];
        end
        core_regs_pkg::POINTER_CHOICE_ADDR: next_cur.pointer_choice = sfr_wdata[core_regs_pkg::CHOICE_BIT];
        core_regs_pkg::CPU_FLAGS_ADDR: begin
          next_cur.carry_flag = sfr_wdata[core_regs_pkg::CARRY_BIT];
          next_cur.nibble_carry_flag = sfr_wdata[core_regs_pkg::NIBBLE_BIT];
          next_cur.user_flag_a = sfr_wdata[core_regs_pkg::USER_A_BIT];
          next_cur.bank_select = sfr_wdata[core_regs_pkg::BANK_HI_BIT:core_regs_pkg::BANK_LO_BIT];
          next_cur.arith_wrap_flag = sfr_wdata[core_regs_pkg::WRAP_BIT];
          next_cur.user_flag_b = sfr_wdata[core_regs_pkg::USER_B_BIT];
        end
        default: begin
        end
      endcase
    end
    // Results of the instruction in flight win over a register write
    // carry and boolean accumulator
    if (bool_wr) begin
      next_cur.carry_flag = bool_val;
    end
    if (alu_upd) begin
      next_cur.carry_flag = alu_carry;
      next_cur.nibble_carry_flag = alu_nibble_carry;
      next_cur.arith_wrap_flag = alu_wrap;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.carry_flag <= 1'b0;
      cur.nibble_carry_flag <= 1'b0;
      cur.user_flag_a <= 1'b0;
      cur.bank_select <= 2'h0;
      cur.arith_wrap_flag <= 1'b0;
      cur.user_flag_b <= 1'b0;
      cur.stack_top <= core_regs_pkg::STACK_TOP_RESET;
      cur.ptr0 <= core_regs_pkg::PTR_RESET;
      cur.ptr1 <= core_regs_pkg::PTR_RESET;
      cur.pointer_choice <= 1'b0;
      cur.wait_states <= core_regs_pkg::WAIT_RESET;
      cur.stretch_cycles <= core_regs_pkg::STRETCH_RESET;
      cur.rdata <= 8'h00;
      cur.x_rd_hit <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sfr_rdata = cur.rdata;
  assign ram_rdata = scratch_rdata;
  assign x_rdata = cur.x_rd_hit ? xram_rdata : 8'h00;
  assign cpu_flags = flags_word(cur, acc);
  assign stack_top = cur.stack_top;
  assign indirect_addr_ptr = active_ptr;
  assign bank_base = bank_addr(cur.bank_select, 3'h0);
  assign wait_states = cur.wait_states;
  assign stretch_cycles = cur.stretch_cycles;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence flags_write_s;
    sfr_wr && sfr_addr == core_regs_pkg::CPU_FLAGS_ADDR;
  endsequence

  sequence push_s;
    push_req && !pop_req && !(sfr_wr && sfr_addr == core_regs_pkg::STACK_TOP_ADDR);
  endsequence

  carry_update_a: assert property (alu_upd |=> cpu_flags[7] == $past(alu_carry))
    else $error("carry flag did not take the result");
  nibble_carry_a: assert property (alu_upd |=> cpu_flags[6] == $past(alu_nibble_carry))
    else $error("nibble carry flag did not take the result");
  bank_reg_a: assert property ((ram_bank_reg && !push_req && !pop_req)
    |-> scratch_addr == {3'h0, cpu_flags[4:3], ram_addr[2:0]})
    else $error("bank register address wrong");
  wrap_flag_a: assert property (alu_upd |=> cpu_flags[2] == $past(alu_wrap))
    else $error("overflow flag did not take the result");
  parity_read_a: assert property ((sfr_rd && sfr_addr == core_regs_pkg::CPU_FLAGS_ADDR)
    |=> sfr_rdata[0] == ^$past(acc))
    else $error("parity bit does not follow accumulator");
  user_flags_a: assert property ((flags_write_s ##1 !sfr_wr [*2]) |-> {cpu_flags[5], cpu_flags[1]}
    == {$past(sfr_wdata[5], 2), $past(sfr_wdata[1], 2)})
    else $error("user flags not held");
  stack_push_a: assert property (push_s |=> stack_top == $past(stack_top) + 8'h01)
    else $error("stack did not advance on push");
  pointer_choice_a: assert property ((sfr_wr && sfr_addr == core_regs_pkg::POINTER_CHOICE_ADDR && !ptr_inc)
    |=> indirect_addr_ptr == ($past(sfr_wdata[0]) ? $past(cur.ptr1) : $past(cur.ptr0)))
    else $error("active pointer not the chosen one");
  xram_window_a: assert property ((x_src == 2'(core_regs_pkg::XSRC_PAGED)) |-> x_hit
    && x_eff[15:8] == core_regs_pkg::PAGE_HIGH)
    else $error("paged access outside page");
  upper_direct_a: assert property ((ram_direct && !ram_bank_reg && ram_addr[7] && !push_req && !pop_req)
    |-> !scratch_wr && !scratch_rd)
    else $error("direct access reached the upper half");

endmodule : core_flags_pointers
`default_nettype wire

// ---- mcu_core_flags_pointers_tb_top.sv ----
// Self-checking testbench for the core flag, pointer and memory map register block
`timescale 1ns/1ps
`default_nettype none
module mcu_core_flags_pointers_tb_top;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  typedef struct {logic [7:0] a; logic [7:0] r; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk, rst_n, sfr_wr, sfr_rd, alu_upd, alu_carry, alu_nibble_carry, alu_wrap, bool_wr, bool_val;
  logic push_req, pop_req, ptr_inc, ram_direct, ram_bank_reg, ram_wr, ram_rd, x_wr, x_rd, x_hit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc, push_data, ram_addr, ram_wdata, ram_rdata;
  logic [7:0] x_wdata, x_rdata, cpu_flags, stack_top, bank_base, v;
  logic [1:0] x_src;
  logic [15:0] x_addr, indirect_addr_ptr;
  logic [2:0] wait_states, stretch_cycles;
  logic h;
  int bad_count, total_checks, cycles;
  row_t rows [9];
  logic [7:0] accs [6] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h7e, 8'h13};

  core_flags_pointers i_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .acc(acc), .alu_upd(alu_upd),
    .alu_carry(alu_carry), .alu_nibble_carry(alu_nibble_carry), .alu_wrap(alu_wrap), .bool_wr(bool_wr),
    .bool_val(bool_val), .push_req(push_req), .pop_req(pop_req), .push_data(push_data), .ptr_inc(ptr_inc),
    .ram_addr(ram_addr), .ram_direct(ram_direct), .ram_bank_reg(ram_bank_reg), .ram_wr(ram_wr),
    .ram_rd(ram_rd), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .x_src(x_src), .x_addr(x_addr),
    .x_wr(x_wr), .x_rd(x_rd), .x_wdata(x_wdata), .x_rdata(x_rdata), .x_hit(x_hit), .cpu_flags(cpu_flags),
    .stack_top(stack_top), .indirect_addr_ptr(indirect_addr_ptr), .bank_base(bank_base),
    .wait_states(wait_states), .stretch_cycles(stretch_cycles));

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Generous ceiling: the whole sequence needs about 125 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(negedge clk);
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask : sfr_read

  task automatic flag_op(input logic u, input logic c, input logic n, input logic w, input logic b);
    @(posedge clk);
    alu_upd <= u;
    alu_carry <= c;
    alu_nibble_carry <= n;
    alu_wrap <= w;
    bool_wr <= b;
    bool_val <= c;
    @(posedge clk);
    alu_upd <= 1'b0;
    bool_wr <= 1'b0;
    @(negedge clk);
  endtask : flag_op

  task automatic ram_op(input logic [7:0] a, input logic dir, input logic bnk, input logic w,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    ram_addr <= a;
    ram_direct <= dir;
    ram_bank_reg <= bnk;
    ram_wr <= w;
    ram_rd <= ~w;
    ram_wdata <= wd;
    @(posedge clk);
    ram_wr <= 1'b0;
    ram_rd <= 1'b0;
    @(negedge clk);
    rd = ram_rdata;
  endtask : ram_op

  task automatic x_op(input logic [1:0] s, input logic [15:0] a, input logic w, input logic [7:0] wd,
                      output logic hit, output logic [7:0] rd);
    @(posedge clk);
    x_src <= s;
    x_addr <= a;
    x_wr <= w;
    x_rd <= ~w;
    x_wdata <= wd;
    @(negedge clk);
    hit = x_hit;
    @(posedge clk);
    x_wr <= 1'b0;
    x_rd <= 1'b0;
    @(negedge clk);
    rd = x_rdata;
  endtask : x_op

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {clk, sfr_wr, sfr_rd, alu_upd, alu_carry, alu_nibble_carry, alu_wrap, bool_wr, bool_val} = '0;
    {push_req, pop_req, ptr_inc, ram_direct, ram_bank_reg, ram_wr, ram_rd, x_wr, x_rd, x_src} = '0;
    {sfr_addr, sfr_wdata, acc, push_data, ram_addr, ram_wdata, x_wdata, x_addr} = '0;
    {bad_count, total_checks, cycles} = '0;
    rst_n = 1'b0;
    // Address, reset value, write data, read back after write; bits 7 and 3 of timing read 0
    rows = '{'{8'h81, 8'h07, 8'h3c, 8'h3c}, '{8'h82, 8'h00, 8'ha5, 8'ha5}, '{8'h83, 8'h00, 8'h5a, 8'h5a},
             '{8'h84, 8'h00, 8'h12, 8'h12}, '{8'h85, 8'h00, 8'h34, 8'h34}, '{8'h8e, 8'h01, 8'h89, 8'h01},
             '{8'h92, 8'h00, 8'hff, 8'h01}, '{8'hd0, 8'h00, 8'hff, 8'hfe}, '{8'h40, 8'h00, 8'hff, 8'h00}};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(wait_states, 3'h0, "wait");
    check(stretch_cycles, 3'h1, "stretch");
    foreach (rows[i]) begin
      sfr_read(rows[i].a, v);
      check(v, rows[i].r, "reset value");
    end
    foreach (rows[i]) begin
      sfr_write(rows[i].a, rows[i].d);
      sfr_read(rows[i].a, v);
      check(v, rows[i].e, "readback");
    end
    $display("test registers done");
    foreach (accs[i]) begin
      @(posedge clk);
      acc <= accs[i];
      @(negedge clk);
      check(cpu_flags[0], ^accs[i], "parity");
    end
    @(posedge clk);
    acc <= 8'h00;
    sfr_write(8'hd0, 8'h10);
    check(bank_base, 8'h10, "bank base");
    ram_op(8'h03, 1'b0, 1'b1, 1'b1, 8'h77, v);
    ram_op(8'h13, 1'b1, 1'b0, 1'b0, 8'h00, v);
    check(v, 8'h77, "bank register");
    flag_op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    check(cpu_flags, 8'h94, "carry wrap");
    flag_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    check(cpu_flags, 8'h50, "nibble carry");
    flag_op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    check(cpu_flags, 8'h50 | 8'h80, "boolean carry");
    sfr_write(8'hd0, 8'h22);
    @(posedge clk);
    acc <= 8'h07;
    @(negedge clk);
    check(cpu_flags, 8'h23, "user flags");
    @(posedge clk);
    acc <= 8'h00;
    $display("test flags done");
    // Push then pop back to back
    @(posedge clk);
    push_req <= 1'b1;
    push_data <= 8'h55;
    @(posedge clk);
    push_req <= 1'b0;
    pop_req <= 1'b1;
    @(negedge clk);
    check(stack_top, 8'h3d, "push");
    @(posedge clk);
    pop_req <= 1'b0;
    @(negedge clk);
    check(ram_rdata, 8'h55, "pop data");
    check(stack_top, 8'h3c, "pop");
    // Indirect write first, so a direct write that slips through shows up
    ram_op(8'h90, 1'b0, 1'b0, 1'b1, 8'h22, v);
    ram_op(8'h90, 1'b1, 1'b0, 1'b1, 8'h11, v);
    ram_op(8'h90, 1'b1, 1'b0, 1'b0, 8'h00, v);
    check(v, 8'h00, "upper direct");
    ram_op(8'h90, 1'b0, 1'b0, 1'b0, 8'h00, v);
    check(v, 8'h22, "upper indirect");
    $display("test stack and scratch done");
    check(indirect_addr_ptr, 16'h3412, "second pointer");
    @(posedge clk);
    ptr_inc <= 1'b1;
    @(posedge clk);
    ptr_inc <= 1'b0;
    sfr_read(8'h84, v);
    check(v, 8'h13, "pointer step");
    sfr_write(8'h92, 8'h00);
    sfr_write(8'h82, 8'hff);
    sfr_write(8'h83, 8'h80);
    check(indirect_addr_ptr, 16'h80ff, "first pointer");
    @(posedge clk);
    ptr_inc <= 1'b1;
    @(posedge clk);
    ptr_inc <= 1'b0;
    @(negedge clk);
    check(indirect_addr_ptr, 16'h8100, "pointer carry");
    x_op(2'd1, 16'h0000, 1'b1, 8'h3c, h, v);
    x_op(2'd0, 16'h8100, 1'b0, 8'h00, h, v);
    check(v, 8'h3c, "pointer access");
    x_op(2'd2, 16'h0012, 1'b1, 8'ha5, h, v);
    check(h, 1'b1, "paged hit");
    x_op(2'd0, 16'h8012, 1'b0, 8'h00, h, v);
    check(v, 8'ha5, "paged data");
    x_op(2'd3, 16'h8012, 1'b0, 8'h00, h, v);
    check({h, v}, 9'h1a5, "source code three");
    x_op(2'd0, 16'h87ff, 1'b1, 8'h69, h, v);
    x_op(2'd0, 16'h87ff, 1'b0, 8'h00, h, v);
    check(v, 8'h69, "top of window");
    x_op(2'd0, 16'h8800, 1'b0, 8'h00, h, v);
    check({h, v}, 9'h000, "above window");
    x_op(2'd0, 16'h7fff, 1'b0, 8'h00, h, v);
    check({h, v}, 9'h000, "below window");
    $display("test pointers and external done");
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(stack_top, 8'h07, "stack reset");
    check(cpu_flags, 8'h00, "flags reset");
    check({wait_states, stretch_cycles}, 6'h01, "timing reset");
    check(indirect_addr_ptr, 16'h0000, "pointer reset");
    @(posedge clk);
    rst_n <= 1'b1;
    sfr_write(8'h92, 8'h01);
    check(indirect_addr_ptr, 16'h0000, "second pointer reset");
    $display("test reset done");
    final_report();
  end
endmodule : mcu_core_flags_pointers_tb_top
`default_nettype wire
